// file: rtl/reset_watchdog.sv
// reset source qualification, start-up delay, reset cause flags and watchdog timer
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "reset_watchdog_cfg.svh"

// Function
// - pin held low past minimum pulse width resets device; short pulses ignored
// - after pin release, reset held until start-up delay expires
// - brownout detector enabled by fuse; level fuse selects 2.7V or 4.0V trip
// - brownout asserts reset at once; release waits start-up delay
// - only supply dips longer than minimum dip time cause brownout reset
// - watchdog expiry gives one-cycle reset pulse; delay starts after it
// - bit 4 flag sets on scan chain reset; cleared by power-on or zero write
// - bit 3 flag sets on watchdog reset; cleared by power-on or zero write
// - bit 2 flag sets on brownout reset; cleared by power-on or zero write
// - bit 1 flag sets on pin reset; cleared by power-on or zero write
// - bit 0 flag sets on power-on; only a zero write clears it
// - bandgap on only with brownout fuse, comparator bandgap select or converter on
// - watchdog counts its own 1 MHz oscillator, not the system clock
// - watchdog counter restarts on restart instruction, disable and chip reset
// - enabled watchdog reaching its period without restart resets the device
// - watchdog control bits 7..5 read zero and ignore writes
// - unlock bit clears by hardware four clocks after written one
// - enable set by writing one; cleared by zero only while unlock is one
// - prescale code 000 gives 16384 oscillator cycles, doubling up to 2097152
// - start-up delay length chosen by clock source fuses
module reset_watchdog
#(
    parameter int unsigned DOG_BASE_PERIOD = `DOG_BASE_PERIOD
)
(
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire reset_watchdog_pkg::wb_req_t wb_req,
    output logic                             wb_ack,
    output logic [31:0]                      wb_dat_o,
    input  wire logic                        pin_reset_n,
    input  wire logic                        supply_below_trip,
    input  wire logic                        brownout_fuse_enable,
    input  wire logic                        brownout_level_select,
    input  wire logic [1:0]                  clock_source_fuses,
    input  wire logic                        scan_reset_instruction,
    input  wire logic                        dog_restart_instruction,
    input  wire logic                        dog_oscillator,
    input  wire logic                        comparator_bandgap_select,
    input  wire logic                        converter_enable,
    output logic                             core_reset,
    output logic                             brownout_detector_enable,
    output logic                             brownout_trip_high,
    output logic                             bandgap_enable
);
    import reset_watchdog_pkg::*;

    localparam logic [`QUAL_COUNT_WIDTH-1:0] PIN_LIMIT =
        `QUAL_COUNT_WIDTH'(`PIN_MIN_PULSE_CYCLES);
    localparam logic [`QUAL_COUNT_WIDTH-1:0] DIP_LIMIT =
        `QUAL_COUNT_WIDTH'(`BROWNOUT_MIN_DIP_CYCLES);
    localparam logic [2:0] UNLOCK_LIMIT = 3'(`UNLOCK_HOLD_CYCLES);

    // start-up delay length picked by the clock source fuses
    function automatic logic [`STARTUP_COUNT_WIDTH-1:0] startup_length(input logic [1:0] fuses);
        logic [`STARTUP_COUNT_WIDTH-1:0] len;
        len = `STARTUP_COUNT_WIDTH'(`STARTUP_CYCLES_0);
        unique case (fuses)
            2'b00: len = `STARTUP_COUNT_WIDTH'(`STARTUP_CYCLES_0);
            2'b01: len = `STARTUP_COUNT_WIDTH'(`STARTUP_CYCLES_1);
            2'b10: len = `STARTUP_COUNT_WIDTH'(`STARTUP_CYCLES_2);
            2'b11: len = `STARTUP_COUNT_WIDTH'(`STARTUP_CYCLES_3);
        endcase
        return len;
    endfunction

    // watchdog period in oscillator cycles, base doubled per prescale step
    function automatic logic [`DOG_COUNT_WIDTH-1:0] dog_period(input logic [2:0] code);
        logic [`DOG_COUNT_WIDTH-1:0] base;
        base = `DOG_COUNT_WIDTH'(DOG_BASE_PERIOD);
        return base << code;
    endfunction

    logic                            pin_low_qual;
    logic [`QUAL_COUNT_WIDTH-1:0]    pin_count;
    logic                            dip_qual;
    logic [`QUAL_COUNT_WIDTH-1:0]    dip_count;
    logic                            dog_pulse;
    logic                            any_source;
    reset_state_t                    state;
    logic [`STARTUP_COUNT_WIDTH-1:0] startup_count;
    logic [4:0]                      cause_flags;
    dog_control_t                    control;
    logic [2:0]                      unlock_count;
    logic                            osc_meta;
    logic                            osc_sync;
    logic                            osc_prev;
    logic                            dog_tick;
    logic [`DOG_COUNT_WIDTH-1:0]     dog_count;
    logic                            bus_write;
    logic                            hit_flags;
    logic                            hit_control;
    logic [7:0]                      wbyte;
    logic                            next_enable;
    logic                            write_flags;
    logic                            write_control;
    logic                            unlock_expired;
    logic                            dog_hold;

    // register decode, shared by the write strobes and the read mux
    function automatic logic addr_match(input logic [3:0] adr, input logic [3:0] offset);
        return (adr == offset);
    endfunction

    // read mux; reserved control bits and unmapped offsets read as zero
    function automatic logic [31:0] read_word(input logic [3:0] adr);
        logic [31:0] word;
        word = '0;
        if (addr_match(adr, `ADDR_RESET_CAUSE_FLAGS))
            word[4:0] = cause_flags;
        else if (addr_match(adr, `ADDR_WATCHDOG_CONTROL))
            word[4:0] = control;
        return word;
    endfunction

    assign bus_write     = wb_req.cyc && wb_req.stb && wb_req.we && wb_ack && wb_req.sel[0];
    assign hit_flags     = addr_match(wb_req.adr, `ADDR_RESET_CAUSE_FLAGS);
    assign hit_control   = addr_match(wb_req.adr, `ADDR_WATCHDOG_CONTROL);
    assign write_flags   = bus_write && hit_flags;
    assign write_control = bus_write && hit_control;
    assign wbyte       = wb_req.dat[7:0];
    assign any_source  = pin_low_qual || dip_qual || scan_reset_instruction || dog_pulse;

    // pin qualification; needs the clock, a stopped clock cannot see the pin
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_count    <= '0;
            pin_low_qual <= 1'b0;
        end
        else if (pin_reset_n)
        begin
            pin_count    <= '0;
            pin_low_qual <= 1'b0;
        end
        else if (pin_count < PIN_LIMIT)
        begin
            pin_count    <= pin_count + 1'b1;
            pin_low_qual <= (pin_count == PIN_LIMIT - 1'b1);
        end
    end

    // brownout dip qualification; fuse off masks the comparator entirely
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            dip_count <= '0;
            dip_qual  <= 1'b0;
        end
        else if (!brownout_fuse_enable || !supply_below_trip)
        begin
            dip_count <= '0;
            dip_qual  <= 1'b0;
        end
        else if (dip_count < DIP_LIMIT)
        begin
            dip_count <= dip_count + 1'b1;
            dip_qual  <= (dip_count == DIP_LIMIT - 1'b1);
        end
    end

    // brownout comparator setup
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            brownout_detector_enable <= 1'b0;
            brownout_trip_high       <= 1'b0;
        end
        else
        begin
            brownout_detector_enable <= brownout_fuse_enable;
            brownout_trip_high       <= brownout_level_select;
        end
    end

    // reference enable; any one of its three users keeps it up
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bandgap_enable <= 1'b0;
        else
            bandgap_enable <= brownout_fuse_enable || comparator_bandgap_select
                              || converter_enable;
    end

    // reset sequencing: hold while any source is active, then stretch
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state         <= ST_HOLD;
            startup_count <= '0;
        end
        else
        begin
            unique case (state)
                ST_HOLD:
                begin
                    startup_count <= '0;
                    if (!any_source)
                        state <= ST_DELAY;
                end
                ST_DELAY:
                begin
                    if (any_source)
                    begin
                        state         <= ST_HOLD;
                        startup_count <= '0;
                    end
                    else if (startup_count == startup_length(clock_source_fuses) - 1'b1)
                        state <= ST_RUN;
                    else
                        startup_count <= startup_count + 1'b1;
                end
                ST_RUN:
                begin
                    if (any_source)
                        state <= ST_HOLD;
                end
                default:
                    state <= ST_HOLD;
            endcase
        end
    end

    // asserted directly from the sources so reset follows them without a cycle lag
    assign core_reset = (state != ST_RUN) || any_source;

    // cause flags; a set in the same cycle as a zero write wins
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cause_flags <= 5'h01;
        else
        begin
            for (int i = 0; i < 5; i++)
            begin
                if (write_flags && !wbyte[i])
                    cause_flags[i] <= 1'b0;
            end
            if (scan_reset_instruction)
                cause_flags[`BIT_SCAN_FLAG] <= 1'b1;
            if (dog_pulse)
                cause_flags[`BIT_DOG_FLAG] <= 1'b1;
            if (dip_qual)
                cause_flags[`BIT_BROWNOUT_FLAG] <= 1'b1;
            if (pin_low_qual)
                cause_flags[`BIT_PIN_FLAG] <= 1'b1;
        end
    end

    always_comb
    begin
        next_enable = control.enable;
        if (write_control)
        begin
            if (wbyte[`BIT_DOG_ENABLE])
                next_enable = 1'b1;
            else if (control.unlock)
                next_enable = 1'b0;
        end
    end

    // window closes on the fourth edge after the arming write
    assign unlock_expired = control.unlock && (unlock_count == UNLOCK_LIMIT - 1'b1);

    // watchdog control; cleared by every reset source, unlike the cause flags which only power-on reset clears
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            control      <= dog_control_t'(5'(`WATCHDOG_CONTROL_RESET));
            unlock_count <= '0;
        end
        else if (any_source)
        begin
            control      <= dog_control_t'(5'(`WATCHDOG_CONTROL_RESET));
            unlock_count <= '0;
        end
        else
        begin
            control.enable <= next_enable;
            if (write_control)
                control.prescale <= wbyte[2:0];
            if (write_control && wbyte[`BIT_DOG_UNLOCK])
            begin
                control.unlock <= 1'b1;
                unlock_count   <= '0;
            end
            else if (control.unlock)
            begin
                unlock_count <= unlock_count + 1'b1;
                if (unlock_expired)
                    control.unlock <= 1'b0;
            end
        end
    end

    // oscillator brought in through two flops; the second and a third delayed copy find its rising edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= dog_oscillator;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign dog_tick = osc_sync && !osc_prev;
    assign dog_hold = core_reset || !control.enable || dog_restart_instruction;

    // watchdog counter; oscillator must run well below half the system clock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            dog_count <= '0;
            dog_pulse <= 1'b0;
        end
        else
        begin
            dog_pulse <= 1'b0;
            if (dog_hold)
                dog_count <= '0;
            else if (dog_tick)
            begin
                if (dog_count == dog_period(control.prescale) - 1'b1)
                begin
                    dog_count <= '0;
                    dog_pulse <= 1'b1;
                end
                else
                    dog_count <= dog_count + 1'b1;
            end
        end
    end

    // bus slave: ack one cycle after request, unmapped reads return zero
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wb_ack   <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack   <= wb_req.cyc && wb_req.stb && !wb_ack;
            wb_dat_o <= read_word(wb_req.adr);
        end
    end

endmodule
`default_nettype wire

// file: rtl/reset_watchdog_cfg.svh
// offsets, field positions, reset values and timing counts for the reset and watchdog block
`ifndef RESET_WATCHDOG_CFG_SVH
`define RESET_WATCHDOG_CFG_SVH

`define CLOCK_PERIOD_NS          4
`define PIN_MIN_PULSE_NS         50
`define PIN_MIN_PULSE_CYCLES     ((`PIN_MIN_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define BROWNOUT_MIN_DIP_NS      2000
`define BROWNOUT_MIN_DIP_CYCLES  ((`BROWNOUT_MIN_DIP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define QUAL_COUNT_WIDTH         10
`define UNLOCK_HOLD_CYCLES       4
`define DOG_BASE_PERIOD          16384
`define DOG_COUNT_WIDTH          22

`define STARTUP_CYCLES_0         64
`define STARTUP_CYCLES_1         256
`define STARTUP_CYCLES_2         1024
`define STARTUP_CYCLES_3         4096
`define STARTUP_COUNT_WIDTH      13

`define ADDR_RESET_CAUSE_FLAGS   4'h0
`define ADDR_WATCHDOG_CONTROL    4'h4

`define BIT_SCAN_FLAG            4
`define BIT_DOG_FLAG             3
`define BIT_BROWNOUT_FLAG        2
`define BIT_PIN_FLAG             1
`define BIT_POWERUP_FLAG         0

`define BIT_DOG_UNLOCK           4
`define BIT_DOG_ENABLE           3
`define WATCHDOG_CONTROL_RESET   8'h00

`endif

// file: rtl/reset_watchdog_pkg.sv
// types shared by the reset and watchdog block
package reset_watchdog_pkg;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        unlock;
        logic        enable;
        logic [2:0]  prescale;
    } dog_control_t;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } reset_state_t;

endpackage

// file: verif/dog_osc_model.sv
// free-running model of the separate watchdog oscillator
`timescale 1ns/1ns
`default_nettype none
module dog_osc_model
#(
    parameter int HALF_NS = 17
)
(
    output logic dog_oscillator
);
    // own source, period 34 ns, no fixed phase to the system clock
    initial dog_oscillator = 1'b0;
    always #(HALF_NS) dog_oscillator = ~dog_oscillator;
endmodule
`default_nettype wire

// file: verif/reset_watchdog_bench.sv
// self-checking bench for the reset and watchdog block
`timescale 1ns/1ns
`default_nettype none
module reset_watchdog_bench;
    import reset_watchdog_pkg::*;
    logic        clock = 1'b0, rst = 1'b1, pin_reset_n = 1'b1;
    wb_req_t     wb_req = '0;
    logic [31:0] wb_dat_o;
    logic        supply_below_trip = 1'b0, brownout_fuse_enable = 1'b0;
    logic        brownout_level_select = 1'b0, scan_reset_instruction = 1'b0;
    logic        dog_restart_instruction = 1'b0, comparator_bandgap_select = 1'b0;
    logic        converter_enable = 1'b0, dog_oscillator;
    logic [1:0]  clock_source_fuses = 2'h0;
    logic        wb_ack, core_reset, brownout_detector_enable, brownout_trip_high, bandgap_enable;
    int          n_mismatch = 0, compares = 0, cycles = 0, n, exp_n;

    always #2 clock = ~clock;

    reset_watchdog #(.DOG_BASE_PERIOD(4)) u_dut (.clock(clock), .rst(rst), .wb_req(wb_req),
        .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .pin_reset_n(pin_reset_n),
        .supply_below_trip(supply_below_trip), .brownout_fuse_enable(brownout_fuse_enable),
        .brownout_level_select(brownout_level_select), .clock_source_fuses(clock_source_fuses),
        .scan_reset_instruction(scan_reset_instruction),
        .dog_restart_instruction(dog_restart_instruction), .dog_oscillator(dog_oscillator),
        .comparator_bandgap_select(comparator_bandgap_select),
        .converter_enable(converter_enable), .core_reset(core_reset),
        .brownout_detector_enable(brownout_detector_enable),
        .brownout_trip_high(brownout_trip_high), .bandgap_enable(bandgap_enable));
    dog_osc_model u_osc (.dog_oscillator(dog_oscillator));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic hold(input int c);
        repeat (c) @(posedge clock);
    endtask
    // one classic cycle; ack is read as sampled at the edge
    task automatic access(input logic we, input logic [3:0] adr, input logic [7:0] d,
        output logic [31:0] q);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
        do
            @(posedge clock);
        while (wb_ack !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] adr, input logic [7:0] d);
        logic [31:0] q;
        access(1'b1, adr, d, q);
    endtask
    task automatic rd(input logic [3:0] adr, input logic [7:0] expv, input string what);
        logic [31:0] q;
        access(1'b0, adr, 8'h00, q);
        check(what, q, {24'h0, expv});
    endtask
    task automatic wait_reset(input logic v, output int c);
        c = 0;
        while (core_reset !== v)
        begin
            @(posedge clock);
            c++;
        end
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    initial
    begin
        hold(20);
        rst <= 1'b0;
        hold(1);
        rd(4'h0, 8'h01, "cause flags");
        rd(4'h4, 8'h00, "control");
        rd(4'h8, 8'h00, "unmapped");
        wait_reset(1'b0, n);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00, "flags cleared");
        wr(4'h4, 8'he7);
        rd(4'h4, 8'h07, "reserved bits");
        wr(4'h4, 8'h00);
        pin_reset_n <= 1'b0;
        hold(6);
        pin_reset_n <= 1'b1;
        hold(6);
        check("short pin", core_reset, 1'b0);
        pin_reset_n <= 1'b0;
        hold(20);
        check("long pin", core_reset, 1'b1);
        pin_reset_n <= 1'b1;
        wait_reset(1'b0, n);
        check("pin delay", n >= 64 && n <= 70, 1'b1);
        rd(4'h0, 8'h02, "pin flag");
        wr(4'h0, 8'h00);
        brownout_fuse_enable <= 1'b1;
        supply_below_trip <= 1'b1;
        hold(100);
        supply_below_trip <= 1'b0;
        hold(6);
        check("short dip", core_reset, 1'b0);
        supply_below_trip <= 1'b1;
        hold(520);
        check("long dip", core_reset, 1'b1);
        supply_below_trip <= 1'b0;
        wait_reset(1'b0, n);
        rd(4'h0, 8'h04, "brownout flag");
        wr(4'h0, 8'h00);
        brownout_fuse_enable <= 1'b0;
        supply_below_trip <= 1'b1;
        hold(600);
        check("fuse off dip", core_reset, 1'b0);
        supply_below_trip <= 1'b0;
        // every longer start-up selection, each started by a scan reset
        for (int f = 1; f < 4; f++)
        begin
            clock_source_fuses <= f[1:0];
            scan_reset_instruction <= 1'b1;
            hold(3);
            check("scan reset", core_reset, 1'b1);
            scan_reset_instruction <= 1'b0;
            wait_reset(1'b0, n);
            exp_n = 64 << (2 * f);
            check("long startup", n + 1 >= exp_n && n <= exp_n + 4, 1'b1);
            rd(4'h0, 8'h10, "scan flag");
            wr(4'h0, 8'h00);
        end
        clock_source_fuses <= 2'h0;
        for (int p = 0; p < 8; p++)
        begin
            {brownout_fuse_enable, comparator_bandgap_select, converter_enable} <= p[2:0];
            brownout_level_select <= p[0];
            hold(3);
            check("bandgap", bandgap_enable, p != 0);
            check("detector copy", brownout_detector_enable, p[2]);
            check("level copy", brownout_trip_high, p[0]);
        end
        brownout_fuse_enable <= 1'b0;
        // oscillator period is 8.5 clocks; window covers phase and sync delay
        for (int p = 0; p < 8; p++)
        begin
            wr(4'h4, 8'h08 + p[7:0]);
            exp_n = (4 << p) * 17 / 2;
            wait_reset(1'b1, n);
            check("dog period", n + 12 >= exp_n && n <= exp_n + 12, 1'b1);
            wait_reset(1'b0, n);
            rd(4'h0, 8'h08, "dog flag");
            rd(4'h4, 8'h00, "control after dog");
            wr(4'h0, 8'h00);
        end
        wr(4'h4, 8'h08);
        repeat (12)
        begin
            hold(16);
            dog_restart_instruction <= 1'b1;
            hold(1);
            dog_restart_instruction <= 1'b0;
        end
        check("restarted dog", core_reset, 1'b0);
        rd(4'h0, 8'h00, "no dog flag");
        wr(4'h4, 8'h0f);
        wr(4'h4, 8'h07);
        rd(4'h4, 8'h0f, "locked enable");
        wr(4'h4, 8'h1f);
        rd(4'h4, 8'h1f, "unlock set");
        wr(4'h4, 8'h07);
        rd(4'h4, 8'h0f, "unlock expired");
        wr(4'h4, 8'h1f);
        wr(4'h4, 8'h07);
        rd(4'h4, 8'h07, "dog disabled");
        hold(4600);
        check("disabled dog", core_reset, 1'b0);
        rd(4'h0, 8'h00, "no dog flag off");
        end_sim();
    end
endmodule
`default_nettype wire

// file: verif/reset_watchdog_monitor.sv
// port-level checks on the reset and watchdog block
`timescale 1ns/1ns
`default_nettype none
module reset_watchdog_monitor
(
    input wire logic                        clock,
    input wire logic                        rst,
    input wire reset_watchdog_pkg::wb_req_t wb_req,
    input wire logic                        wb_ack,
    input wire logic [31:0]                 wb_dat_o,
    input wire logic                        pin_reset_n,
    input wire logic                        supply_below_trip,
    input wire logic                        brownout_fuse_enable,
    input wire logic                        brownout_level_select,
    input wire logic                        scan_reset_instruction,
    input wire logic                        comparator_bandgap_select,
    input wire logic                        converter_enable,
    input wire logic                        core_reset,
    input wire logic                        brownout_detector_enable,
    input wire logic                        brownout_trip_high,
    input wire logic                        bandgap_enable
);
    import reset_watchdog_pkg::*;
    logic [4:0] pin_low;
    logic [9:0] dip_low;
    // saturating run lengths, so long holds never wrap
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst || pin_reset_n)
            pin_low <= 5'h00;
        else if (pin_low != 5'h1f)
            pin_low <= pin_low + 5'h01;
    end
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst || !(supply_below_trip && brownout_detector_enable))
            dip_low <= 10'h000;
        else if (dip_low != 10'h3ff)
            dip_low <= dip_low + 10'h001;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_pin_long_resets: assert property (pin_low >= 5'h0d |-> ##[0:3] core_reset)
        else $error("long pin low gave no reset");
    a_pin_release_held: assert property ($rose(pin_reset_n) && core_reset |=> core_reset[*8])
        else $error("reset left early after pin release");
    a_dip_long_resets: assert property (dip_low >= 10'h1f4 |-> ##[0:4] core_reset)
        else $error("long supply dip gave no reset");
    a_scan_holds_reset: assert property (scan_reset_instruction |-> core_reset)
        else $error("scan source without reset");
    a_scan_delay_held: assert property ($fell(scan_reset_instruction) |-> core_reset[*8])
        else $error("no start-up delay after scan reset");
    a_fuse_copy_follows: assert property (1'b1 |=> brownout_detector_enable ==
        $past(brownout_fuse_enable) && brownout_trip_high == $past(brownout_level_select))
        else $error("fuse copies wrong");
    a_bandgap_enable_or: assert property (1'b1 |=> bandgap_enable ==
        ($past(brownout_fuse_enable) || $past(comparator_bandgap_select) || $past(converter_enable)))
        else $error("bandgap enable wrong");
    a_reserved_read_zero: assert property (wb_ack && wb_req.adr == 4'h4 |-> wb_dat_o[7:5] == 3'h0)
        else $error("reserved control bits not zero");
    c_pin_reset: cover property (pin_low == 5'h0d);
    c_reset_release: cover property ($fell(core_reset));
    c_bus_write: cover property (wb_ack && wb_req.we);
endmodule
bind reset_watchdog reset_watchdog_monitor u_monitor (.clock(clock), .rst(rst), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .pin_reset_n(pin_reset_n),
    .supply_below_trip(supply_below_trip), .brownout_fuse_enable(brownout_fuse_enable),
    .brownout_level_select(brownout_level_select), .scan_reset_instruction(scan_reset_instruction),
    .comparator_bandgap_select(comparator_bandgap_select), .converter_enable(converter_enable),
    .core_reset(core_reset), .brownout_detector_enable(brownout_detector_enable),
    .brownout_trip_high(brownout_trip_high), .bandgap_enable(bandgap_enable));
`default_nettype wire
